// File: pwseq_core.sv
// Power waveform sequencer: command interpreter with program memory
//
// Operation
// - Code 2 moves power linearly to parameter-2 watts over parameter-1 milliseconds.
// - Code 3 moves power toward parameter-2 watts at parameter-1 watts per millisecond.
// - Code 4 waits for sync low, high, rising, falling edge, or a delay in ms by sub-code 1..5.
// - Code 5 jumps to line 0..99 only while sync is low (-1) or high (-2), else falls through.
// - Code 5 with a count loops back that many times, then falls through.
// - Each command holds a one-byte code, a two-byte first and a four-byte second parameter.
// - Emission on with a program selected raises executing; normal end raises complete.
// - Emission off during execution aborts and raises abnormal.
// - Program number zero means programming mode is inactive.
`timescale 1ns/10ps
`include "pwseq_defines.svh"
module pwseq_core
#(
    parameter int unsigned LINES      = 100,
    parameter int unsigned PROGS      = 8,
    parameter int unsigned MS_CYCLES  = `PWSEQ_MS_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_prog,
    input  wire logic [6:0]  wr_line,
    input  wire logic [7:0]  wr_code,
    input  wire logic [15:0] wr_param1,
    input  wire logic [31:0] wr_param2,
    input  wire logic [2:0]  prog_sel,
    input  wire logic        emission_on,
    input  wire logic        sync_in,
    output logic             sync_out,
    output logic [15:0]      power_w,
    output logic             prog_mode,
    output logic             executing,
    output logic             complete,
    output logic             abnormal
);
    import pwseq_pkg::*;

    localparam int unsigned DEPTH = LINES * PROGS;

    // One word per line: code, first parameter, second parameter
    logic [7:0]         mem_code [DEPTH];
    logic [15:0]        mem_p1   [DEPTH];
    logic [31:0]        mem_p2   [DEPTH];

    logic               rst_m, rst_n;
    logic               sync_m, sync_s, sync_d;
    logic               emis_m, emis_s, emis_d;
    pwseq_state_e       state, next_state;
    logic [6:0]         line, next_line;
    logic [7:0]         code, next_code;
    logic [15:0]        p1, next_p1;
    logic [31:0]        p2, next_p2;
    logic [2:0]         prog, next_prog;
    logic [31:0]        pwr_fx, next_pwr_fx;
    // Wide enough for a full-scale 65000 W step in one millisecond, either way
    logic signed [32:0] step, next_step;
    logic signed [33:0] pwr_sum, tgt_fx;
    logic [15:0]        ms_left, next_ms_left;
    logic [19:0]        loops [LINES];
    logic [19:0]        loop_cur, loop_val;
    logic               loop_wr, tick, tick_restart, emis_rise, emis_fall;
    logic               next_sync_out, next_executing, next_complete, next_abnormal;

    function automatic logic [9:0] addr_of(input logic [2:0] pg, input logic [6:0] ln);
        addr_of = 10'(pg * LINES + ln);
    endfunction

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // Pins from the machine controller are asynchronous to clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_m <= 1'b0;
            sync_s <= 1'b0;
            sync_d <= 1'b0;
            emis_m <= 1'b0;
            emis_s <= 1'b0;
            emis_d <= 1'b0;
        end else begin
            sync_m <= sync_in;
            sync_s <= sync_m;
            sync_d <= sync_s;
            emis_m <= emission_on;
            emis_s <= emis_m;
            emis_d <= emis_s;
        end
    end

    assign emis_rise = emis_s & ~emis_d;
    assign emis_fall = ~emis_s & emis_d;

    // Programs are written only while idle; no reset so it maps to block RAM
    always_ff @(posedge clk) begin
        if (wr_en && state == PWSEQ_IDLE && wr_line <= `PWSEQ_MAX_LINE) begin
            mem_code[addr_of(wr_prog, wr_line)] <= wr_code;
            mem_p1[addr_of(wr_prog, wr_line)]   <= wr_param1;
            mem_p2[addr_of(wr_prog, wr_line)]   <= wr_param2;
        end
    end

    assign loop_cur  = loops[line];
    assign prog_mode = (prog_sel != 3'h0);
    assign power_w   = pwr_fx[31:16];
    assign pwr_sum   = $signed({2'h0, pwr_fx}) + 34'(step);
    assign tgt_fx    = $signed({2'h0, p2[15:0], 16'h0000});

    pwseq_ms_tick #(
        .CYCLES  (MS_CYCLES)
    ) u_tick (
        .clk     (clk),
        .rst_n   (rst_n),
        .restart (tick_restart),
        .tick    (tick)
    );

    always_comb begin
        next_state     = state;
        next_line      = line;
        next_code      = code;
        next_p1        = p1;
        next_p2        = p2;
        next_prog      = prog;
        next_pwr_fx    = pwr_fx;
        next_step      = step;
        next_ms_left   = ms_left;
        next_sync_out  = sync_out;
        next_executing = executing;
        next_complete  = complete;
        next_abnormal  = abnormal;
        tick_restart   = 1'b0;
        loop_wr        = 1'b0;
        loop_val       = 20'h00000;
        if (state != PWSEQ_IDLE && emis_fall) begin
            next_state     = PWSEQ_IDLE;
            next_executing = 1'b0;
            next_abnormal  = 1'b1;
        end else begin
            unique case (state)
                PWSEQ_IDLE: begin
                    if (emis_rise && prog_sel != 3'h0) begin
                        next_prog      = prog_sel;
                        next_line      = 7'h00;
                        next_executing = 1'b1;
                        next_complete  = 1'b0;
                        next_abnormal  = 1'b0;
                        next_state     = PWSEQ_FETCH;
                    end
                end
                PWSEQ_FETCH: begin
                    next_code  = mem_code[addr_of(prog, line)];
                    next_p1    = mem_p1[addr_of(prog, line)];
                    next_p2    = mem_p2[addr_of(prog, line)];
                    next_state = PWSEQ_EXEC;
                end
                PWSEQ_EXEC: begin
                    next_state   = PWSEQ_FETCH;
                    next_line    = line + 7'h01;
                    tick_restart = 1'b1;
                    unique case (code)
                        `PWSEQ_OP_TRAMP: begin
                            // Fixed point 16.16 so short ramps keep fine slopes
                            next_ms_left = p1;
                            if (p1 == 16'h0000) begin
                                next_pwr_fx = {p2[15:0], 16'h0000};
                            end else begin
                                next_step  = 33'((tgt_fx - $signed({2'h0, pwr_fx})) /
                                                 $signed({18'h0, p1}));
                                next_state = PWSEQ_RAMP;
                            end
                        end
                        `PWSEQ_OP_RRAMP: begin
                            next_ms_left = 16'hFFFF;
                            next_step    = (p2[15:0] >= power_w) ?
                                           $signed({1'h0, p1, 16'h0000}) :
                                           -$signed({1'h0, p1, 16'h0000});
                            next_state   = PWSEQ_RAMP;
                        end
                        `PWSEQ_OP_WAIT: begin
                            next_ms_left = p2[15:0];
                            next_state   = (p1 == `PWSEQ_W_DELAY) ? PWSEQ_DELAY : PWSEQ_WAIT;
                        end
                        `PWSEQ_OP_BRANCH: begin
                            if (p2 == `PWSEQ_BR_LOW) begin
                                if (!sync_s) next_line = p1[6:0];
                            end else if (p2 == `PWSEQ_BR_HIGH) begin
                                if (sync_s) next_line = p1[6:0];
                            end else if (loop_cur < p2[19:0]) begin
                                loop_wr   = 1'b1;
                                loop_val  = loop_cur + 20'h00001;
                                next_line = p1[6:0];
                            end else begin
                                loop_wr   = 1'b1;
                                loop_val  = 20'h00000;
                            end
                        end
                        `PWSEQ_OP_OUT: begin
                            if (p2 == `PWSEQ_OUT_LOW) next_sync_out = 1'b0;
                            if (p2 == `PWSEQ_OUT_HIGH) next_sync_out = 1'b1;
                        end
                        default: begin
                            // Stop, or any unknown code, ends the run cleanly
                            next_state     = PWSEQ_IDLE;
                            next_executing = 1'b0;
                            next_complete  = 1'b1;
                        end
                    endcase
                end
                PWSEQ_RAMP: begin
                    if (tick) begin
                        next_pwr_fx  = pwr_sum[31:0];
                        next_ms_left = ms_left - 16'h0001;
                        // Rate ramp clamps at the target so it never overshoots
                        if (code == `PWSEQ_OP_RRAMP) begin
                            if ((step >= 0 && pwr_sum >= tgt_fx) ||
                                (step < 0 && pwr_sum <= tgt_fx) || p1 == 16'h0000) begin
                                next_pwr_fx = {p2[15:0], 16'h0000};
                                next_state  = PWSEQ_FETCH;
                            end
                        end else if (ms_left == 16'h0001) begin
                            next_pwr_fx = {p2[15:0], 16'h0000};
                            next_state  = PWSEQ_FETCH;
                        end
                    end
                end
                PWSEQ_WAIT: begin
                    unique case (p1)
                        `PWSEQ_W_LOW:  if (!sync_s) next_state = PWSEQ_FETCH;
                        `PWSEQ_W_HIGH: if (sync_s) next_state = PWSEQ_FETCH;
                        `PWSEQ_W_RISE: if (sync_s && !sync_d) next_state = PWSEQ_FETCH;
                        `PWSEQ_W_FALL: if (!sync_s && sync_d) next_state = PWSEQ_FETCH;
                        default:       next_state = PWSEQ_FETCH;
                    endcase
                end
                PWSEQ_DELAY: begin
                    if (ms_left == 16'h0000) next_state = PWSEQ_FETCH;
                    else if (tick) next_ms_left = ms_left - 16'h0001;
                end
                default: next_state = PWSEQ_IDLE;
            endcase
        end
    end

    // Loop counters are per line and cleared at each start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LINES; i++) loops[i] <= 20'h00000;
        end else if (state == PWSEQ_IDLE) begin
            for (int i = 0; i < LINES; i++) loops[i] <= 20'h00000;
        end else if (loop_wr) begin
            loops[line] <= loop_val;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= PWSEQ_IDLE;
            line      <= 7'h00;
            code      <= 8'h00;
            p1        <= 16'h0000;
            p2        <= 32'h00000000;
            prog      <= 3'h0;
            pwr_fx    <= 32'h00000000;
            step      <= 33'sh0;
            ms_left   <= 16'h0000;
            sync_out  <= 1'b0;
            executing <= 1'b0;
            complete  <= 1'b0;
            abnormal  <= 1'b0;
        end else begin
            state     <= next_state;
            line      <= next_line;
            code      <= next_code;
            p1        <= next_p1;
            p2        <= next_p2;
            prog      <= next_prog;
            pwr_fx    <= next_pwr_fx;
            step      <= next_step;
            ms_left   <= next_ms_left;
            sync_out  <= next_sync_out;
            executing <= next_executing;
            complete  <= next_complete;
            abnormal  <= next_abnormal;
        end
    end
endmodule

// File: pwseq_core_properties.sv
// Port-level assertions for the power waveform sequencer
`timescale 1ns/10ps
module pwseq_core_properties (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [2:0] prog_sel,
    input  wire logic       emission_on,
    input  wire logic       sync_out,
    input  wire logic       prog_mode,
    input  wire logic       executing,
    input  wire logic       complete,
    input  wire logic       abnormal
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_run_ends;
        $fell(executing);
    endsequence
    sequence s_run_starts;
        $rose(executing);
    endsequence

    chk_mode_select: assert property (prog_mode == (prog_sel != 3'h0))
        else $error("programming mode does not follow the program number");
    chk_start_cause: assert property (s_run_starts |-> prog_sel != 3'h0 && $past(emission_on, 2))
        else $error("run started without emission and a selected program");
    chk_done_ends: assert property ($rose(complete) |-> s_run_ends and !abnormal)
        else $error("completion raised without the run ending");
    chk_abort_ends: assert property ($rose(abnormal) |-> s_run_ends and !emission_on)
        else $error("abnormal raised without emission off ending the run");
    chk_abort_bound: assert property ($fell(emission_on) && executing |-> ##[1:8] !executing)
        else $error("run not aborted after emission off");
    chk_run_floor: assert property (s_run_starts |=> executing || abnormal)
        else $error("run ended before fetch and execute of a line");
    chk_flags_clear: assert property ($fell(complete) || $fell(abnormal) |-> executing)
        else $error("status flag cleared outside a new start");
    chk_flag_exclusive: assert property (executing |-> !complete && !abnormal)
        else $error("end flag shown while executing");
    chk_sync_hold: assert property (!executing |=> $stable(sync_out))
        else $error("sync output changed while no program runs");
    cover property ($rose(complete));
endmodule

// File: pwseq_ctrl_model.sv
// Machine controller model driving sync in and watching sync out
`timescale 1ns/10ps
module pwseq_ctrl_model (
    input  wire logic clk,
    input  wire logic sync_out,
    output logic      sync_in
);
    int   rises    = 0;
    logic last_out = 1'b0;
    initial sync_in = 1'b0;
    // Level is held between calls, as a real controller output would be
    task automatic drive(input logic level, input int delay);
        repeat (delay + 1) @(posedge clk);
        #5 sync_in = level;
    endtask
    always @(posedge clk) begin
        if (sync_out === 1'b1 && last_out === 1'b0) rises++;
        last_out <= sync_out;
    end
endmodule

// File: pwseq_defines.svh
// Constants of the power waveform sequencer
`ifndef PWSEQ_DEFINES_SVH
`define PWSEQ_DEFINES_SVH
`define PWSEQ_CLK_HZ        20000000
`define PWSEQ_MS_CYCLES     (`PWSEQ_CLK_HZ / 1000)
`define PWSEQ_OP_STOP       8'h01
`define PWSEQ_OP_TRAMP      8'h02
`define PWSEQ_OP_RRAMP      8'h03
`define PWSEQ_OP_WAIT       8'h04
`define PWSEQ_OP_BRANCH     8'h05
`define PWSEQ_OP_OUT        8'h06
`define PWSEQ_W_LOW         16'h0001
`define PWSEQ_W_HIGH        16'h0002
`define PWSEQ_W_RISE        16'h0003
`define PWSEQ_W_FALL        16'h0004
`define PWSEQ_W_DELAY       16'h0005
`define PWSEQ_BR_LOW        32'hFFFFFFFF
`define PWSEQ_BR_HIGH       32'hFFFFFFFE
`define PWSEQ_MAX_LINE      7'h63
`define PWSEQ_OUT_LOW       32'h00000001
`define PWSEQ_OUT_HIGH      32'h00000002
`endif

// File: pwseq_ms_tick.sv
// Millisecond tick generator for the sequencer
`timescale 1ns/10ps
`include "pwseq_defines.svh"
module pwseq_ms_tick #(
    parameter int unsigned CYCLES = `PWSEQ_MS_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic restart,
    output logic      tick
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic        next_tick;

    // Restart aligns the first tick a full millisecond after a command starts
    always_comb begin
        next_cnt  = cnt + 32'h00000001;
        next_tick = 1'b0;
        if (restart) begin
            next_cnt = 32'h00000000;
        end else if (cnt >= CYCLES - 1) begin
            next_cnt  = 32'h00000000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= 32'h00000000;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// File: pwseq_pkg.sv
// Types of the power waveform sequencer
package pwseq_pkg;
    typedef enum logic [2:0] {
        PWSEQ_IDLE,
        PWSEQ_FETCH,
        PWSEQ_EXEC,
        PWSEQ_RAMP,
        PWSEQ_WAIT,
        PWSEQ_DELAY
    } pwseq_state_e;
endpackage

// File: pwseq_tb.sv
// Self-checking bench for the power waveform sequencer
`timescale 1ns/10ps
`include "pwseq_defines.svh"
module testbench;
    localparam int unsigned MS = 4;
    logic        clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, emission_on = 1'b0;
    logic [2:0]  wr_prog = 3'h0, prog_sel = 3'h0;
    logic [6:0]  wr_line = 7'h00;
    logic [7:0]  wr_code = 8'h00;
    logic [15:0] wr_param1 = 16'h0000, power_w, peak;
    logic [31:0] wr_param2 = 32'h0;
    logic        sync_in, sync_out, prog_mode, executing, complete, abnormal;
    int          num_errors = 0, n_compared = 0, run_len, n, r0;

    always #25 clk = ~clk;
    pwseq_core #(.MS_CYCLES(MS)) dut (.clk(clk), .resetn(resetn), .wr_en(wr_en),
        .wr_prog(wr_prog), .wr_line(wr_line), .wr_code(wr_code), .wr_param1(wr_param1),
        .wr_param2(wr_param2), .prog_sel(prog_sel), .emission_on(emission_on),
        .sync_in(sync_in), .sync_out(sync_out), .power_w(power_w), .prog_mode(prog_mode),
        .executing(executing), .complete(complete), .abnormal(abnormal));
    pwseq_ctrl_model ctrl (.clk(clk), .sync_out(sync_out), .sync_in(sync_in));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Code, two-byte and four-byte fields go in as one line
    task automatic wr(input logic [2:0] p, input logic [6:0] l, input logic [7:0] c,
                      input logic [15:0] a, input logic [31:0] b);
        @(posedge clk);
        #5 {wr_en, wr_prog, wr_line, wr_code, wr_param1, wr_param2} = {1'b1, p, l, c, a, b};
        @(posedge clk);
        #5 wr_en = 1'b0;
    endtask
    task automatic run(input logic [2:0] p, input int limit);
        @(posedge clk);
        #5 {prog_sel, emission_on} = {p, 1'b1};
        n = 0;
        while (executing !== 1'b1 && n < 20) begin @(posedge clk); #1 n++; end
        check("executing", 1, executing);
        run_len = 0;
        peak = 16'h0000;
        while (executing === 1'b1 && run_len < limit) begin
            @(posedge clk);
            #1 run_len++;
            if (power_w > peak) peak = power_w;
        end
        check("complete", 1, complete);
        #4 emission_on = 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic test_ramps();
        wr(1, 0, `PWSEQ_OP_OUT, 0, `PWSEQ_OUT_HIGH);
        wr(1, 1, `PWSEQ_OP_TRAMP, 16'h2, 32'h64);
        wr(1, 2, `PWSEQ_OP_RRAMP, 16'h19, 32'h32);
        wr(1, 3, `PWSEQ_OP_STOP, 0, 0);
        run(1, 200);
        check("ramp peak", 32'h64, peak);
        check("ramp final", 32'h32, power_w);
        check("ramp span", 1, run_len >= 4 * MS && run_len <= 4 * MS + 16);
        check("sync high", 1, sync_out);
        wr(6, 0, `PWSEQ_OP_RRAMP, 16'hFDE8, 32'hFDE8);
        wr(6, 1, `PWSEQ_OP_TRAMP, 16'h1, 32'h0);
        wr(6, 2, `PWSEQ_OP_STOP, 0, 0);
        run(6, 100);
        check("full scale peak", 32'hFDE8, peak);
        check("full scale final", 32'h0, power_w);
        $display("test ramps done");
    endtask
    task automatic test_waits();
        wr(2, 0, `PWSEQ_OP_OUT, 0, `PWSEQ_OUT_LOW);
        wr(2, 1, `PWSEQ_OP_WAIT, `PWSEQ_W_HIGH, 0);
        wr(2, 2, `PWSEQ_OP_WAIT, `PWSEQ_W_LOW, 0);
        wr(2, 3, `PWSEQ_OP_WAIT, `PWSEQ_W_RISE, 0);
        wr(2, 4, `PWSEQ_OP_WAIT, `PWSEQ_W_FALL, 0);
        wr(2, 5, `PWSEQ_OP_OUT, 0, `PWSEQ_OUT_HIGH);
        wr(2, 6, `PWSEQ_OP_WAIT, `PWSEQ_W_DELAY, 32'h3);
        wr(2, 7, `PWSEQ_OP_OUT, 0, `PWSEQ_OUT_LOW);
        wr(2, 8, `PWSEQ_OP_STOP, 0, 0);
        fork
            run(2, 400);
            begin
                repeat (25) @(posedge clk);
                #1 check("stalled on high", 1, executing & ~sync_out);
                ctrl.drive(1, 0);
                ctrl.drive(0, 10);
                ctrl.drive(1, 10);
                ctrl.drive(0, 10);
                n = 0;
                while (sync_out !== 1'b1 && n < 50) begin @(posedge clk); #1 n++; end
                n = 0;
                while (sync_out !== 1'b0 && n < 50) begin @(posedge clk); #1 n++; end
                check("delay span", 1, n >= 3 * MS && n <= 3 * MS + 6);
            end
        join
        $display("test waits done");
    endtask
    task automatic test_loop();
        wr(3, 0, `PWSEQ_OP_OUT, 0, `PWSEQ_OUT_LOW);
        wr(3, 1, `PWSEQ_OP_OUT, 0, `PWSEQ_OUT_HIGH);
        wr(3, 2, `PWSEQ_OP_BRANCH, 16'h0, 32'h2);
        wr(3, 3, `PWSEQ_OP_STOP, 0, 0);
        repeat (2) begin
            r0 = ctrl.rises;
            run(3, 200);
            check("loop passes", 3, ctrl.rises - r0);
        end
        $display("test loop done");
    endtask
    task automatic test_branch();
        wr(4, 0, `PWSEQ_OP_OUT, 0, `PWSEQ_OUT_LOW);
        wr(4, 1, `PWSEQ_OP_BRANCH, 16'h3, `PWSEQ_BR_HIGH);
        wr(4, 2, `PWSEQ_OP_BRANCH, 16'h4, `PWSEQ_BR_LOW);
        wr(4, 3, `PWSEQ_OP_OUT, 0, `PWSEQ_OUT_HIGH);
        wr(4, 4, `PWSEQ_OP_STOP, 0, 0);
        run(4, 100);
        check("branch on low", 0, sync_out);
        ctrl.drive(1, 0);
        run(4, 100);
        check("branch on high", 1, sync_out);
        $display("test branch done");
    endtask
    task automatic test_abort();
        wr(5, 0, `PWSEQ_OP_WAIT, `PWSEQ_W_DELAY, 32'hEA60);
        wr(5, 1, `PWSEQ_OP_STOP, 0, 0);
        @(posedge clk);
        #5 prog_sel = 3'h0;
        #1 check("mode off", 0, prog_mode);
        @(posedge clk);
        #5 emission_on = 1'b1;
        repeat (20) @(posedge clk);
        check("no start unselected", 0, executing);
        #5 emission_on = 1'b0;
        repeat (6) @(posedge clk);
        #5 {prog_sel, emission_on} = {3'h5, 1'b1};
        repeat (30) @(posedge clk);
        check("mode on", 1, prog_mode);
        check("long delay running", 1, executing);
        #5 emission_on = 1'b0;
        repeat (10) @(posedge clk);
        check("aborted", 3'b010, {executing, abnormal, complete});
        $display("test abort done");
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #5 resetn = 1'b1;
        repeat (3) @(posedge clk);
        test_ramps();
        test_waits();
        test_loop();
        test_branch();
        test_abort();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        test_done();
    end
endmodule

bind pwseq_core pwseq_core_properties u_props (.clk(clk), .resetn(resetn),
    .prog_sel(prog_sel), .emission_on(emission_on), .sync_out(sync_out),
    .prog_mode(prog_mode), .executing(executing), .complete(complete), .abnormal(abnormal));
